// >>> core/csc_pkg.sv
// shared types and constants of the clock source and start-up control block
// Functional notes
// - decode clock source fuse field into four sources
// - fuse bit one unprogrammed, zero programmed
// - wake from deep sleep counts source cycles
// - reset adds delay timed by watchdog oscillator
// - reset time-out 4096 or 65536 watchdog cycles
// - default internal RC, longest start-up, divide-by-eight
// - upper three crystal bits choose amplifier range
// - crystal low bit 0, start-up 00/01: 258 cycles
// - three crystal selections use 1K wake delay
// - crystal low bit 1, start-up 01-11: 16K cycles
// - sleep modes halt unused module clocks
// - external interrupt, serial start wake every sleep mode
// - flash clock gated together with core clock
// - async timer clock runs in power-save while rest sleeps
// - converter clock runs with core, peripheral halted
// - internal RC: 6 cycle wake, 14 cycle reset
// - low-frequency crystal: 1K/32K wake, 4 cycle reset
// - reset loads factory oscillator calibration value
package csc_pkg;
    localparam int CNT_W = 17;
    typedef logic [CNT_W-1:0] csc_cnt_t;

    // register byte offsets on the bus
    localparam logic [3:0] REG_FUSE = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_CAL = 4'hc;

    typedef struct packed {
        logic div8;
        logic [1:0] startup_time_fuses;
        logic [3:0] clock_source_select_fuses;
    } csc_fuse_t;

    // internal RC, start-up 10, divide-by-eight programmed
    localparam logic [6:0] FUSE_DEFAULT = 7'h22;

    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_EXT_CLK = 4'h0;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_INT_RC = 4'h2;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_LF_1K = 4'h6;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_LF_32K = 4'h7;
    localparam logic [1:0] SUT_00 = 2'h0;
    localparam logic [1:0] SUT_01 = 2'h1;
    localparam logic [1:0] SUT_10 = 2'h2;
    localparam logic [2:0] XKEY_258_SHORT = 3'h0;
    localparam logic [2:0] XKEY_258_LONG = 3'h1;
    localparam logic [2:0] XKEY_1K_NONE = 3'h2;
    localparam logic [2:0] XKEY_1K_SHORT = 3'h3;
    localparam logic [2:0] XKEY_1K_LONG = 3'h4;
    localparam logic [2:0] XKEY_16K_NONE = 3'h5;
    localparam logic [2:0] XKEY_16K_SHORT = 3'h6;

    localparam csc_cnt_t WAKE_6_CK = 17'h00006;
    localparam csc_cnt_t WAKE_258_CK = 17'h00102;
    localparam csc_cnt_t WAKE_1K_CK = 17'h00400;
    localparam csc_cnt_t RST_14_CK = 17'h0000e;
    localparam csc_cnt_t RST_4_CK = 17'h00004;
    localparam csc_cnt_t TIMEOUT_SHORT = 17'h01000;
    localparam csc_cnt_t CNT_ZERO = 17'h00000;

    typedef enum logic [1:0] {SRC_XTAL = 2'b00, SRC_LF = 2'b01, SRC_RC = 2'b10, SRC_EXT = 2'b11} csc_src_t;
    typedef enum logic [1:0] {TO_NONE = 2'b00, TO_SHORT = 2'b01, TO_LONG = 2'b10} csc_to_t;
    typedef enum logic [2:0] {
        SLP_IDLE = 3'b000,
        SLP_ADC = 3'b001,
        SLP_PDOWN = 3'b010,
        SLP_PSAVE = 3'b011,
        SLP_STANDBY = 3'b110
    } csc_sleep_t;

    typedef struct packed {
        logic core;
        logic periph;
        logic flash;
        logic async_timer;
        logic converter;
    } csc_clk_en_t;

    typedef struct packed {
        csc_cnt_t wake;
        csc_cnt_t rst_src;
        csc_to_t timeout;
    } csc_startup_t;

    // control register fields
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_RESTART_BIT = 4;

    // synchroniser slots
    localparam int N_SYNC = 4;
    localparam int SYN_SRC = 0;
    localparam int SYN_WDT = 1;
    localparam int SYN_EXT = 2;
    localparam int SYN_USI = 3;
endpackage

// >>> core/csc_tick_sync.sv
// three-stage synchroniser with agreed level and rising-edge pulse
`timescale 1ns/1ps
module csc_tick_sync
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic rise_reg;
    wire agree = (s2_reg == s3_reg);

    always_ff @(posedge clk_i)
    begin
        s1_reg <= async_i;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end
        else
        begin
            if (agree)
            begin
                level_reg <= s2_reg;
            end
            rise_reg <= agree && s2_reg && !level_reg;
        end
    end

    assign level_o = level_reg;
    assign rise_o = rise_reg;
endmodule

// >>> core/csc_delay_counter.sv
// loadable down counter of external ticks with done flag
`timescale 1ns/1ps
module csc_delay_counter
    import csc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire csc_cnt_t target_i,
    input wire logic tick_i,
    output logic done_o,
    output csc_cnt_t left_o
);
    csc_cnt_t cnt_reg;
    logic busy_reg;
    wire last = (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= CNT_ZERO;
            busy_reg <= 1'b0;
        end
        else if (start_i)
        begin
            cnt_reg <= target_i;
            busy_reg <= (target_i != CNT_ZERO);
        end
        else if (busy_reg && tick_i)
        begin
            cnt_reg <= cnt_reg - 1'b1;
            busy_reg <= !last;
        end
    end

    assign done_o = !busy_reg;
    assign left_o = cnt_reg;
endmodule

// >>> core/csc_clock_ctrl.sv
// clock source selection, start-up timing and clock domain gating
`timescale 1ns/1ps
module csc_clock_ctrl
    import csc_pkg::*;
#(
    parameter csc_cnt_t WAKE_16K_CK = 17'h04000,
    parameter csc_cnt_t WAKE_32K_CK = 17'h08000,
    parameter csc_cnt_t TIMEOUT_LONG = 17'h10000
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic src_clk_i,
    input wire logic wdt_osc_i,
    input wire logic ext_int_i,
    input wire logic usi_start_i,
    input wire logic [7:0] factory_cal_i,
    output logic internal_rst_o,
    output csc_clk_en_t clk_en_o,
    output csc_src_t src_sel_o,
    output logic [2:0] xtal_range_o,
    output logic div8_o,
    output logic [7:0] osc_cal_o
);
    typedef enum logic [2:0] {
        ST_LOAD = 3'b000,
        ST_RST_SRC = 3'b001,
        ST_RST_WDT = 3'b010,
        ST_RUN = 3'b011,
        ST_SLEEP = 3'b100,
        ST_WAKE = 3'b101
    } csc_state_t;

    // reserved codes fall back to the internal RC source
    function automatic csc_src_t src_of(input logic [3:0] clock_source_select_fuses);
        return clock_source_select_fuses[3] ? SRC_XTAL : (clock_source_select_fuses == CLOCK_SOURCE_SELECT_FUSES_LF_1K || clock_source_select_fuses == CLOCK_SOURCE_SELECT_FUSES_LF_32K) ? SRC_LF :
            (clock_source_select_fuses == CLOCK_SOURCE_SELECT_FUSES_EXT_CLK) ? SRC_EXT : SRC_RC;
    endfunction

    function automatic logic is_reserved(input logic [3:0] clock_source_select_fuses);
        return !clock_source_select_fuses[3] && clock_source_select_fuses != CLOCK_SOURCE_SELECT_FUSES_LF_1K && clock_source_select_fuses != CLOCK_SOURCE_SELECT_FUSES_LF_32K
            && clock_source_select_fuses != CLOCK_SOURCE_SELECT_FUSES_INT_RC && clock_source_select_fuses != CLOCK_SOURCE_SELECT_FUSES_EXT_CLK;
    endfunction

    // reserved start-up code 11 is taken as the longest delay
    function automatic csc_to_t to_of(input logic [1:0] startup_time_fuses);
        return (startup_time_fuses == SUT_00) ? TO_NONE : (startup_time_fuses == SUT_01) ? TO_SHORT : TO_LONG;
    endfunction

    function automatic csc_startup_t startup_of(input csc_fuse_t f);
        csc_startup_t r;
        logic [2:0] key;
        key = {f.clock_source_select_fuses[0], f.startup_time_fuses};
        r.wake = WAKE_6_CK;
        r.rst_src = RST_14_CK;
        r.timeout = to_of(f.startup_time_fuses);
        unique case (src_of(f.clock_source_select_fuses))
            SRC_XTAL:
            begin
                r.wake = (key <= XKEY_258_LONG) ? WAKE_258_CK : (key <= XKEY_1K_LONG) ? WAKE_1K_CK : WAKE_16K_CK;
                r.timeout = (key == XKEY_1K_NONE || key == XKEY_16K_NONE) ? TO_NONE :
                            (key == XKEY_258_SHORT || key == XKEY_1K_SHORT) ? TO_SHORT :
                            (key == XKEY_16K_SHORT) ? TO_SHORT : TO_LONG;
            end
            SRC_LF:
            begin
                r.wake = f.clock_source_select_fuses[0] ? WAKE_32K_CK : WAKE_1K_CK;
                r.rst_src = RST_4_CK;
            end
            // internal RC and external clock delays
            SRC_RC, SRC_EXT:
            begin
                r.wake = WAKE_6_CK;
            end
        endcase
        return r;
    endfunction

    function automatic csc_clk_en_t gate_of(input csc_state_t st, input csc_sleep_t m);
        csc_clk_en_t e;
        e = '{core: 1'b1, periph: 1'b1, flash: 1'b1, async_timer: 1'b1, converter: 1'b1};
        if (st == ST_SLEEP || st == ST_WAKE)
        begin
            e.core = 1'b0;
            e.flash = 1'b0;
            e.periph = (m == SLP_IDLE);
            e.converter = (m == SLP_IDLE) || (m == SLP_ADC);
            e.async_timer = (m != SLP_PDOWN) && (m != SLP_STANDBY);
        end
        else if (st != ST_RUN)
        begin
            e = '{core: 1'b0, periph: 1'b0, flash: 1'b0, async_timer: 1'b0, converter: 1'b0};
        end
        return e;
    endfunction

    csc_state_t state_reg;
    csc_state_t state_next;
    csc_fuse_t fuse_reg;
    csc_fuse_t act_reg;
    csc_sleep_t mode_reg;
    logic [7:0] cal_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic rst_out_reg;
    csc_clk_en_t en_reg;
    csc_src_t src_reg;
    logic [2:0] range_reg;
    logic div8_reg;
    logic restart_reg;

    logic [N_SYNC-1:0] sync_in;
    logic [N_SYNC-1:0] sync_level;
    logic [N_SYNC-1:0] sync_rise;
    assign sync_in = {usi_start_i, ext_int_i, wdt_osc_i, src_clk_i};

    genvar gi;
    generate
        for (gi = 0; gi < N_SYNC; gi++)
        begin : g_sync
            csc_tick_sync u_sync
            (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .async_i(sync_in[gi]),
                .level_o(sync_level[gi]),
                .rise_o(sync_rise[gi])
            );
        end
    endgenerate

    // bus decode
    wire bus_req = cyc_i && stb_i && !ack_reg;
    wire wr_lane0 = bus_req && we_i && sel_i[0];
    wire hit_fuse = (adr_i == REG_FUSE);
    wire hit_ctrl = (adr_i == REG_CTRL);
    wire hit_status = (adr_i == REG_STATUS);
    wire hit_cal = (adr_i == REG_CAL);
    wire wr_fuse = wr_lane0 && hit_fuse;
    wire wr_ctrl = wr_lane0 && hit_ctrl;
    wire wr_cal = wr_lane0 && hit_cal;
    wire sleep_go = wr_ctrl && dat_i[CTRL_GO_BIT];
    wire restart_go = wr_ctrl && dat_i[CTRL_RESTART_BIT];
    wire [2:0] mode_wr = dat_i[CTRL_MODE_LSB+2:CTRL_MODE_LSB];
    // new mode already gates the clocks in the cycle sleep is entered
    wire csc_sleep_t mode_eff = (wr_ctrl && state_reg == ST_RUN) ? csc_sleep_t'(mode_wr) : mode_reg;

    // fuses latched at load, live image used only in the load cycle
    wire csc_fuse_t cfg = (state_reg == ST_LOAD) ? fuse_reg : act_reg;
    wire csc_startup_t su = startup_of(cfg);
    wire cfg_err = is_reserved(act_reg.clock_source_select_fuses);

    wire csc_cnt_t to_cycles = (su.timeout == TO_SHORT) ? TIMEOUT_SHORT :
                               (su.timeout == TO_LONG) ? TIMEOUT_LONG : CNT_ZERO;

    // asynchronous wake sources, independent of peripheral clock
    wire wake_evt = sync_level[SYN_EXT] || sync_rise[SYN_USI];
    wire slow_wake = (mode_reg == SLP_PDOWN) || (mode_reg == SLP_PSAVE);

    logic start_src;
    logic start_wdt;
    csc_cnt_t src_target;
    logic src_done;
    logic wdt_done;
    csc_cnt_t src_left;

    always_comb
    begin
        state_next = state_reg;
        start_src = 1'b0;
        start_wdt = 1'b0;
        src_target = su.rst_src;
        unique case (state_reg)
            ST_LOAD:
            begin
                start_src = 1'b1;
                state_next = ST_RST_SRC;
            end
            ST_RST_SRC:
            begin
                // watchdog oscillator times the extra delay
                if (src_done)
                begin
                    start_wdt = 1'b1;
                    state_next = ST_RST_WDT;
                end
            end
            ST_RST_WDT:
            begin
                if (wdt_done)
                begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (restart_reg)
                begin
                    state_next = ST_LOAD;
                end
                else if (sleep_go)
                begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                if (wake_evt && slow_wake)
                begin
                    start_src = 1'b1;
                    src_target = su.wake;
                    state_next = ST_WAKE;
                end
                else if (wake_evt)
                begin
                    state_next = ST_RUN;
                end
            end
            ST_WAKE:
            begin
                if (src_done)
                begin
                    state_next = ST_RUN;
                end
            end
            default:
            begin
                state_next = ST_LOAD;
            end
        endcase
    end

    csc_delay_counter u_src_cnt
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(start_src),
        .target_i(src_target),
        .tick_i(sync_rise[SYN_SRC]),
        .done_o(src_done),
        .left_o(src_left)
    );

    csc_delay_counter u_wdt_cnt
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(start_wdt),
        .target_i(to_cycles),
        .tick_i(sync_rise[SYN_WDT]),
        .done_o(wdt_done),
        .left_o()
    );

    wire in_reset_next = (state_next == ST_LOAD) || (state_next == ST_RST_SRC) || (state_next == ST_RST_WDT);
    wire [31:0] status_word = {12'h000, src_left[15:0], cfg_err, state_reg};
    wire [31:0] rd_word = hit_fuse ? {25'h0000000, fuse_reg} :
                          hit_ctrl ? {28'h0000000, mode_reg, 1'b0} :
                          hit_status ? status_word :
                          hit_cal ? {24'h000000, cal_reg} : 32'h00000000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_LOAD;
            fuse_reg <= FUSE_DEFAULT;
            act_reg <= FUSE_DEFAULT;
            mode_reg <= SLP_IDLE;
            restart_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == ST_LOAD)
            begin
                act_reg <= fuse_reg;
            end
            if (wr_fuse)
            begin
                fuse_reg <= dat_i[6:0];
            end
            if (wr_ctrl && state_reg == ST_RUN)
            begin
                mode_reg <= csc_sleep_t'(mode_wr);
            end
            restart_reg <= restart_go || (restart_reg && state_reg != ST_RUN);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || state_reg == ST_LOAD)
        begin
            cal_reg <= factory_cal_i;
        end
        else if (wr_cal)
        begin
            cal_reg <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end
        else
        begin
            ack_reg <= bus_req;
            dat_reg <= (bus_req && !we_i) ? rd_word : 32'h00000000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rst_out_reg <= 1'b1;
            en_reg <= gate_of(ST_LOAD, SLP_IDLE);
            src_reg <= SRC_RC;
            range_reg <= 3'h0;
            div8_reg <= 1'b1;
        end
        else
        begin
            // internal reset held through both counts
            rst_out_reg <= in_reset_next;
            en_reg <= gate_of(state_next, mode_eff);
            src_reg <= src_of(cfg.clock_source_select_fuses);
            range_reg <= (src_of(cfg.clock_source_select_fuses) == SRC_XTAL) ? cfg.clock_source_select_fuses[3:1] : 3'h0;
            div8_reg <= !cfg.div8;
        end
    end

    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
    assign internal_rst_o = rst_out_reg;
    assign clk_en_o = en_reg;
    assign src_sel_o = src_reg;
    assign xtal_range_o = range_reg;
    assign div8_o = div8_reg;
    assign osc_cal_o = cal_reg;
endmodule

// >>> tb/csc_osc_model.sv
// free-running source and watchdog oscillator models with edge counters
`timescale 1ns/1ps
module csc_osc_model
(
    output logic src_clk_o,
    output logic wdt_osc_o,
    output int src_edges_o,
    output int wdt_edges_o
);
    logic src_q = 1'b0;
    logic wdt_q = 1'b0;
    int src_cnt = 0;
    int wdt_cnt = 0;
    // watchdog period unrelated to the system clock, source period four system clocks
    always #50 src_q = ~src_q;
    always #65 wdt_q = ~wdt_q;
    always @(posedge src_q) src_cnt++;
    always @(posedge wdt_q) wdt_cnt++;
    assign src_clk_o = src_q;
    assign wdt_osc_o = wdt_q;
    assign src_edges_o = src_cnt;
    assign wdt_edges_o = wdt_cnt;
endmodule

// >>> tb/csc_clock_ctrl_checker.sv
// port assertions of the clock control block
`timescale 1ns/1ps
module csc_clock_ctrl_checker
    import csc_pkg::*;
#(
    parameter csc_cnt_t WAKE_16K_CK = 17'h04000,
    parameter csc_cnt_t WAKE_32K_CK = 17'h08000,
    parameter csc_cnt_t TIMEOUT_LONG = 17'h10000
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic src_clk_i,
    input wire logic wdt_osc_i,
    input wire logic ext_int_i,
    input wire logic usi_start_i,
    input wire logic [7:0] factory_cal_i,
    input wire logic internal_rst_o,
    input wire csc_clk_en_t clk_en_o,
    input wire csc_src_t src_sel_o,
    input wire logic [2:0] xtal_range_o,
    input wire logic div8_o,
    input wire logic [7:0] osc_cal_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_answer;
        disable iff (rst_i) cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
    property p_dat_idle;
        !ack_o |-> dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_rst_outs;
        rst_i |=> internal_rst_o && clk_en_o == 5'h00 && src_sel_o == SRC_RC && div8_o;
    endproperty
    a_rst_outs: assert property (p_rst_outs) else $error("bad outputs in reset");
    property p_cal_load;
        rst_i |=> osc_cal_o == $past(factory_cal_i);
    endproperty
    a_cal_load: assert property (p_cal_load) else $error("calibration not loaded");
    property p_range;
        disable iff (rst_i) (src_sel_o == SRC_XTAL) ? xtal_range_o[2] : xtal_range_o == 3'h0;
    endproperty
    a_range: assert property (p_range) else $error("bad crystal range");
    property p_flash;
        clk_en_o.flash == clk_en_o.core;
    endproperty
    a_flash: assert property (p_flash) else $error("flash clock apart from core");
    property p_core_rst;
        internal_rst_o |-> !clk_en_o.core;
    endproperty
    a_core_rst: assert property (p_core_rst) else $error("core clock in reset");
    property p_rst_hold;
        $fell(rst_i) |-> internal_rst_o [*8];
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset released early");
    property p_async;
        disable iff (rst_i) clk_en_o.periph || clk_en_o.converter |-> clk_en_o.async_timer;
    endproperty
    a_async: assert property (p_async) else $error("async clock stopped");
    property p_conv;
        disable iff (rst_i) clk_en_o.periph |-> clk_en_o.converter;
    endproperty
    a_conv: assert property (p_conv) else $error("converter clock stopped");
    c_xtal: cover property (src_sel_o == SRC_XTAL && !internal_rst_o);
    c_sleep: cover property (!internal_rst_o && !clk_en_o.core);
    c_wake: cover property ($rose(clk_en_o.core));
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the clock source and start-up control block
`timescale 1ns/1ps
module tb_top
    import csc_pkg::*;
;
    localparam csc_cnt_t W16 = 17'h00028;
    localparam csc_cnt_t W32 = 17'h0003c;
    localparam csc_cnt_t TL = 17'h00050;
    localparam logic [7:0] WF [7] = '{8'h02, 8'h18, 8'h19, 8'h07, 8'h06, 8'h28, 8'h00};
    localparam int WW [7] = '{6, 258, W16, W32, 1024, 1024, 6};
    localparam logic [2:0] MD [4] = '{3'h0, 3'h1, 3'h3, 3'h6};
    localparam logic [4:0] ME [4] = '{5'h0b, 5'h03, 5'h02, 5'h00};
    logic clk_i, rst_i, we_i, cyc_i, stb_i, ext_int_i, usi_start_i, ack_o, internal_rst_o, div8_o, src_clk, wdt_osc;
    logic [3:0] adr_i, sel_i, c;
    logic [31:0] dat_i, dat_o, rd;
    logic [7:0] osc_cal_o;
    logic [7:0] factory_cal_i = 8'ha5;
    logic [2:0] xtal_range_o;
    logic [1:0] s;
    csc_clk_en_t clk_en_o;
    csc_src_t src_sel_o, es;
    int src_n, wdt_n, mismatches, checks_done, src0, wdt0;
    csc_osc_model u_csc_osc_model (.src_clk_o(src_clk), .wdt_osc_o(wdt_osc), .src_edges_o(src_n), .wdt_edges_o(wdt_n));
    csc_clock_ctrl #(.WAKE_16K_CK(W16), .WAKE_32K_CK(W32), .TIMEOUT_LONG(TL)) u_csc_clock_ctrl (.clk_i(clk_i),
        .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .dat_o(dat_o), .ack_o(ack_o), .src_clk_i(src_clk), .wdt_osc_i(wdt_osc), .ext_int_i(ext_int_i),
        .usi_start_i(usi_start_i), .factory_cal_i(factory_cal_i), .internal_rst_o(internal_rst_o),
        .clk_en_o(clk_en_o), .src_sel_o(src_sel_o), .xtal_range_o(xtal_range_o), .div8_o(div8_o),
        .osc_cal_o(osc_cal_o));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack_o !== 1'b1 && k < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        chk("ack", 1, k < 20);
    endtask
    // waits for core clock when core is set, else for reset release
    task automatic wait_sig(input bit core);
        int k;
        k = 0;
        while ((core ? clk_en_o.core : !internal_rst_o) !== 1'b1 && k < 40000)
        begin
            @(posedge clk_i);
            k++;
        end
        chk("wait", 1, k < 40000);
    endtask
    task automatic cfg(input logic [7:0] f);
        wb(1'b1, REG_FUSE, {24'h0, f});
        wb(1'b1, REG_CTRL, 32'h10);
        wdt0 = wdt_n;
        repeat (4) @(posedge clk_i);
        wait_sig(1'b0);
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial
    begin
        #2000000;
        mismatches++;
        end_of_test();
    end
    initial
    begin
        {rst_i, we_i, cyc_i, stb_i, ext_int_i, usi_start_i} = 6'h20;
        {adr_i, dat_i} = 36'h0;
        sel_i = 4'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wdt0 = wdt_n;
        @(posedge clk_i);
        chk("div8", 1, div8_o);
        chk("src", SRC_RC, src_sel_o);
        wb(1'b0, REG_FUSE, 32'h0);
        chk("fuse", 32'h22, rd);
        wb(1'b0, REG_CAL, 32'h0);
        chk("cal", 32'ha5, rd);
        wb(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, rd);
        wait_sig(1'b0);
        chk("long_to", 1, wdt_n - wdt0 >= TL && wdt_n - wdt0 <= TL + 20);
        wb(1'b1, REG_CAL, 32'h5a);
        wb(1'b0, REG_CAL, 32'h0);
        chk("cal_w", 32'h5a, rd);
        cfg(8'h52);
        chk("short_to", 1, wdt_n - wdt0 >= 4096 && wdt_n - wdt0 <= 4116);
        wb(1'b0, REG_CAL, 32'h0);
        chk("cal_reload", 32'ha5, rd);
        chk("osc_cal", 32'ha5, osc_cal_o);
        for (int i = 0; i < 16; i++)
        begin
            c = i[3:0];
            s = (c < 4'h8) ? 2'b00 : (c[0] ? 2'b01 : 2'b10);
            cfg({2'b01, s, c});
            es = c[3] ? SRC_XTAL : (c[3:1] == 3'h3 ? SRC_LF : (c == 4'h0 ? SRC_EXT : SRC_RC));
            chk("src_sel", es, src_sel_o);
            chk("range", c[3] ? c[3:1] : 3'h0, xtal_range_o);
            chk("div8_off", 0, div8_o);
            wb(1'b0, REG_STATUS, 32'h0);
            chk("rsvd", c inside {4'h1, 4'h3, 4'h4, 4'h5}, rd[3]);
        end
        for (int i = 0; i < 7; i++)
        begin
            cfg(WF[i]);
            wb(1'b1, REG_CTRL, 32'h5);
            repeat (2) @(posedge clk_i);
            chk("pd_en", 0, clk_en_o);
            ext_int_i <= 1'b1;
            src0 = src_n;
            wait_sig(1'b1);
            ext_int_i <= 1'b0;
            chk("wake", 1, src_n - src0 >= WW[i] - 1 && src_n - src0 <= WW[i] + 4);
        end
        for (int i = 0; i < 4; i++)
        begin
            // let the synced wake level fall before sleeping again
            repeat (6) @(posedge clk_i);
            wb(1'b1, REG_CTRL, {28'h0, MD[i], 1'b1});
            repeat (2) @(posedge clk_i);
            chk("slp_en", ME[i], clk_en_o);
            if (i[0])
                usi_start_i <= 1'b1;
            else
                ext_int_i <= 1'b1;
            wait_sig(1'b1);
            usi_start_i <= 1'b0;
            ext_int_i <= 1'b0;
        end
        end_of_test();
    end
endmodule
bind csc_clock_ctrl csc_clock_ctrl_checker #(.WAKE_16K_CK(WAKE_16K_CK), .WAKE_32K_CK(WAKE_32K_CK),
    .TIMEOUT_LONG(TIMEOUT_LONG)) u_csc_clock_ctrl_checker (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .src_clk_i(src_clk_i), .wdt_osc_i(wdt_osc_i), .ext_int_i(ext_int_i), .usi_start_i(usi_start_i),
    .factory_cal_i(factory_cal_i), .internal_rst_o(internal_rst_o), .clk_en_o(clk_en_o),
    .src_sel_o(src_sel_o), .xtal_range_o(xtal_range_o), .div8_o(div8_o), .osc_cal_o(osc_cal_o));
